//--- dv/iie_field.sv
`timescale 1ns/100ps
// field contacts: steady levels, contact 4 may chatter at clock rate
module iie_field (
  input  wire logic       clk_sys,  // chatter timing
  input  wire logic [7:0] level,    // commanded contact levels
  input  wire logic       chatter,  // bounce contact 4
  output logic      [7:0] pins      // levels seen at the inputs
);
  logic flip = 1'b0;  // bounce phase
  // a bouncing contact flips every cycle, it never settles while chattering
  always_ff @(posedge clk_sys) begin
    flip <= chatter ? ~flip : 1'b0;
  end
  assign pins = level ^ {3'h0, flip, 4'h0};
endmodule // iie_field

//--- dv/iie_unit_sva.sv
`timescale 1ns/100ps
module iie_unit_sva (
  input wire logic                clk_sys,
  input wire logic                resetn,
  input wire logic [7:0]          isolated_input_n,
  input wire iie_pkg::iie_wbreq_s wb_req,
  input wire iie_pkg::iie_wbrsp_s wb_rsp,
  input wire logic                irq
);
  import iie_pkg::*;
  logic        take;    // request taken at this edge
  logic        wr_clr;  // taken write that may lower irq
  logic        ien;     // copy of the shared irq enable
  logic [7:0]  filt;    // copy of the filter enables
  logic        rd_st;   // last taken read hit the state byte
  logic        rd_gap;  // last taken read hit the unmapped gap
  logic [15:0] stab;    // cycles the inputs stayed unchanged
  assign take = wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  assign wr_clr = take && wb_req.we && wb_req.adr >= 32'(A_IRQ_EN)
                  && wb_req.adr <= 32'(A_OPEND);
  // shadow the few registers the properties depend on
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ien <= 1'b0;
      filt <= 8'h00;
      rd_st <= 1'b0;
      rd_gap <= 1'b0;
      stab <= 16'h0000;
    end else begin
      if (take) begin
        rd_st <= !wb_req.we && wb_req.adr == 32'(A_STATE);
        rd_gap <= !wb_req.we && wb_req.adr >= 32'h30 && wb_req.adr < 32'h40;
      end
      if (take && wb_req.we && wb_req.adr == 32'(A_IRQ_EN)) ien <= wb_req.dat[8];
      if (take && wb_req.we && wb_req.adr == 32'(A_FILT_EN)) filt <= wb_req.dat[7:0];
      // restart the count on any input or filter change
      if ($changed(isolated_input_n) || (take && wb_req.adr == 32'(A_FILT_EN))) stab <= 16'h0;
      else if (stab != 16'hffff) stab <= stab + 16'h1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_ack_next: assert property (take |=> wb_rsp.ack) else $error("no ack after request");
  a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
  a_ack_cause: assert property (wb_rsp.ack |-> $past(take)) else $error("ack without request");
  a_gap_zero: assert property (wb_rsp.ack && rd_gap |-> wb_rsp.dat == 32'h0)
    else $error("unmapped read not zero");
  a_state_follow: assert property (
    wb_rsp.ack && rd_st && filt == 8'h00 && stab > 16'd2510
    |-> wb_rsp.dat[7:0] == isolated_input_n) else $error("state byte stale");
  a_irq_gated: assert property (!ien && !$past(ien) |-> !irq)
    else $error("irq while disabled");
  a_irq_hold: assert property (
    irq && ien && !wr_clr && !$past(wr_clr) |=> irq) else $error("irq dropped alone");
  a_irq_fall: assert property (
    $fell(irq) |-> $past(wr_clr) || $past(wr_clr, 2)) else $error("irq fell uncleared");
  c_irq: cover property ($rose(irq));
  c_state: cover property (wb_rsp.ack && rd_st && stab > 16'd2510);
  c_gap: cover property (wb_rsp.ack && rd_gap);
endmodule // iie_unit_sva
bind iie_unit iie_unit_sva u_sva (.clk_sys(clk_sys), .resetn(resetn),
  .isolated_input_n(isolated_input_n), .wb_req(wb_req), .wb_rsp(wb_rsp), .irq(irq));

//--- dv/test_isolated_input_event_unit.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
  end \
end
module test_isolated_input_event_unit;
  import iie_pkg::*;
  logic        clk_sys = 1'b0;  // 25 MHz system clock
  logic        resetn = 1'b0;   // active low reset
  logic [7:0]  lvl = 8'h00;     // commanded contact levels
  logic        chatter = 1'b0;  // bounce contact 4
  logic [7:0]  pins;            // field side of the inputs
  iie_wbreq_s  req = '0;        // bus request
  iie_wbrsp_s  rsp;             // bus answer
  logic        irq;             // shared interrupt
  logic [31:0] rdat;            // last read data
  logic [15:0] cnt_exp [3] = '{16'hfffe, 16'hffff, 16'hfffd};  // counter after each event
  int          error_cnt = 0;
  int          total_checks = 0;
  always #20 clk_sys = ~clk_sys;
  iie_field u_field (.clk_sys(clk_sys), .level(lvl), .chatter(chatter), .pins(pins));
  iie_unit u_dut (.clk_sys(clk_sys), .resetn(resetn), .isolated_input_n(pins),
    .wb_req(req), .wb_rsp(rsp), .irq(irq));
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one classic cycle, held until ack is sampled at an edge
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{adr: {24'h0, a}, dat: d, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.ack !== 1'b1 && n < 16);
    rdat = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    `CHK(rsp.ack, 1'b1)
    if (rsp.ack !== 1'b1) tally_and_finish();
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  // a little over one 100 us sample period
  task automatic step();
    repeat (2540) @(posedge clk_sys);
  endtask
  // one high pulse on a channel, each level lasting a sample period
  task automatic pulse(input int ch);
    lvl[ch] <= 1'b1;
    step();
    lvl[ch] <= 1'b0;
    step();
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    chk_rd(A_CH_BASE + 8'(C_HI), 32'h2);
    chk_rd(A_CH_BASE + 8'(C_LO), 32'h2);
    chk_rd(A_COS_MODE, 32'h3);
    wb(1'b1, 8'h30, 32'hffff_ffff);
    chk_rd(8'h30, 32'h0);
    lvl <= 8'ha4;
    step();
    chk_rd(A_STATE, 32'ha4);
    // chattering contact behind the filter must not get through
    wb(1'b1, A_FILT_EN, 32'h10);
    chatter <= 1'b1;
    step();
    step();
    chk_rd(A_STATE, 32'ha4);
    chatter <= 1'b0;
    wb(1'b1, A_FILT_EN, 32'h0);
    // channel 1 counter started near the top of its range
    wb(1'b1, 8'h68, 32'hfffd);
    wb(1'b1, 8'h6c, 32'hfffe);
    wb(1'b1, A_IRQ_EN, 32'h10c);
    wb(1'b1, A_CNT_EN, 32'h2);
    chk_rd(8'h70, 32'hfffd);
    for (int i = 0; i < 3; i++) begin
      pulse(1);
      chk_rd(8'h70, {16'h0, cnt_exp[i]});
    end
    chk_rd(A_MPEND, 32'h2);
    chk_rd(A_OPEND, 32'h2);
    `CHK(irq, 1'b1)
    wb(1'b1, A_CNT_EN, 32'h0);
    wb(1'b1, A_CNT_EDGE, 32'h2);
    pulse(1);
    chk_rd(8'h70, 32'hfffd);
    wb(1'b1, A_CNT_EN, 32'h2);
    lvl[1] <= 1'b1;
    step();
    chk_rd(8'h70, 32'hfffd);
    lvl[1] <= 1'b0;
    step();
    chk_rd(8'h70, 32'hfffe);
    wb(1'b1, A_MPEND, 32'hff);
    wb(1'b1, A_OPEND, 32'hff);
    chk_rd(A_PEND, 32'h0);
    `CHK(irq, 1'b0)
    // change of state watched on channel 2 only
    wb(1'b1, A_IRQ_EN, 32'h102);
    wb(1'b1, A_COS_EN, 32'h4);
    wb(1'b1, A_COS_MODE, 32'h1);
    lvl[2] <= 1'b0;
    lvl[3] <= 1'b1;
    step();
    chk_rd(A_PEND, 32'h0);
    lvl[2] <= 1'b1;
    step();
    chk_rd(A_PEND, 32'h2);
    wb(1'b1, A_PEND, 32'h2);
    wb(1'b1, A_COS_MODE, 32'h2);
    lvl[2] <= 1'b0;
    step();
    chk_rd(A_PEND, 32'h2);
    wb(1'b1, A_PEND, 32'h2);
    // pattern on channel 0, channel 5 is a don't-care
    wb(1'b1, A_IRQ_EN, 32'h101);
    wb(1'b1, A_PM_VAL, 32'h1);
    wb(1'b1, A_PM_EN, 32'h1);
    lvl[0] <= 1'b1;
    step();
    chk_rd(A_PEND, 32'h1);
    `CHK(irq, 1'b1)
    wb(1'b1, A_PEND, 32'h1);
    lvl[5] <= 1'b0;
    step();
    chk_rd(A_PEND, 32'h0);
    tally_and_finish();
  end
endmodule // test_isolated_input_event_unit

//--- rtl/iie_pkg.sv
package iie_pkg;
  localparam int NCH = 8;                              // channel count
  localparam int CLK_HZ = 25000000;                    // system clock rate
  localparam int SAMPLE_US = 100;                      // fast sample period, us
  localparam int FILTER_MS = 5;                        // filter tick period, ms
  localparam int SAMPLE_CYC = (CLK_HZ / 1000000) * SAMPLE_US;  // cycles per sample tick
  localparam int FILTER_TICKS = (FILTER_MS * 1000) / SAMPLE_US; // sample ticks per filter tick
  localparam logic [15:0] FILT_MIN = 16'h0002;         // smallest sampling number
  // register word offsets (byte addresses)
  localparam logic [7:0] A_STATE    = 8'h00;  // ro: reported states
  localparam logic [7:0] A_FILT_EN  = 8'h04;  // filter enables
  localparam logic [7:0] A_PM_EN    = 8'h08;  // pattern-match enables
  localparam logic [7:0] A_PM_VAL   = 8'h0c;  // pattern value
  localparam logic [7:0] A_COS_EN   = 8'h10;  // change-of-state enables
  localparam logic [7:0] A_COS_MODE = 8'h14;  // [0] rising, [1] falling
  localparam logic [7:0] A_CNT_EN   = 8'h18;  // counter enables
  localparam logic [7:0] A_CNT_EDGE = 8'h1c;  // 1 = falling edge counts
  localparam logic [7:0] A_IRQ_EN   = 8'h20;  // [0] pm [1] cos [2] match [3] ovf
  localparam logic [7:0] A_PEND     = 8'h24;  // pending, write 1 to clear [1:0]; [3:2] read only
  localparam logic [7:0] A_MPEND    = 8'h28;  // per-channel match pending, w1c
  localparam logic [7:0] A_OPEND    = 8'h2c;  // per-channel overflow pending, w1c
  localparam logic [7:0] A_CH_BASE  = 8'h40;  // per-channel block base
  localparam int CH_STRIDE = 32;               // bytes per channel block
  localparam logic [4:0] C_HI  = 5'h00;  // high sample count
  localparam logic [4:0] C_LO  = 5'h04;  // low sample count
  localparam logic [4:0] C_RLD = 5'h08;  // reload value
  localparam logic [4:0] C_MAT = 5'h0c;  // match value
  localparam logic [4:0] C_CNT = 5'h10;  // ro: counter value
  localparam logic [15:0] FILT_RST = 16'h0002;  // sample count after reset
  localparam logic [15:0] A_TOP = 16'(A_CH_BASE) + 16'(NCH * CH_STRIDE) - 16'h0001; // last address
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
    logic        cyc;
    logic        stb;
  } iie_wbreq_s;
  typedef struct packed {
    logic [31:0] dat;
    logic        ack;
  } iie_wbrsp_s;
endpackage

//--- rtl/iie_unit.sv
`timescale 1ns/100ps
module iie_unit (
  input  wire logic                clk_sys,          // system clock
  input  wire logic                resetn,           // async reset, active low
  input  wire logic [7:0]          isolated_input_n, // field inputs, asynchronous
  input  wire iie_pkg::iie_wbreq_s wb_req,           // wishbone request
  output iie_pkg::iie_wbrsp_s      wb_rsp,           // wishbone answer
  output logic                     irq               // shared interrupt
);
  import iie_pkg::*;

  // all state of the block
  typedef struct packed {
    logic [7:0]      sync1;      // synchroniser stage one
    logic [7:0]      sync2;      // synchroniser stage two
    logic [11:0]     div;        // sample divider
    logic [5:0]      fdiv;       // filter tick divider
    logic [7:0]      state;      // reported states
    logic [7:0]      state_q;    // last reported states for edges
    logic            pm_q;       // match condition last cycle
    logic [7:0]      filt_en;
    logic [7:0]      pm_en;
    logic [7:0]      pm_val;
    logic [7:0]      cos_en;
    logic [1:0]      cos_mode;
    logic [7:0]      cnt_en;
    logic [7:0]      cnt_edge;
    logic            irq_en;
    logic [1:0]      pend;       // [0] pattern, [1] change of state
    logic [7:0]      mpend;      // counter match pending
    logic [7:0]      opend;      // counter overflow pending
    logic [3:0]      src_en;     // source enables
    logic [NCH-1:0][15:0] hi_n;  // high sample numbers
    logic [NCH-1:0][15:0] lo_n;  // low sample numbers
    logic [NCH-1:0][15:0] fcnt;  // filter persistence counts
    logic [NCH-1:0][15:0] rld;   // reload values
    logic [NCH-1:0][15:0] mat;   // match values
    logic [NCH-1:0][15:0] cnt;   // event counters
    logic            ack;
    logic [31:0]     rdat;
    logic            irq;
  } iie_st_s;

  iie_st_s st;       // registered state
  iie_st_s next_st;  // next state

  // clamp a sampling number into its legal range
  function automatic logic [15:0] clamp_n(input logic [15:0] v);
    clamp_n = (v < FILT_MIN) ? FILT_MIN : v;
  endfunction

  logic       tick;     // 100 us sample tick
  logic       ftick;    // 5 ms filter tick
  logic [7:0] ch;       // selected channel in block area
  logic [4:0] creg;     // register within channel block
  logic       in_ch;    // address hits channel area
  logic       wr;       // write strobe taken this cycle
  logic [7:0] wrb;      // low byte of write data, lane gated
  logic [15:0] wrh;     // low half of write data, lane gated
  logic [7:0] rise;     // reported rising edges
  logic [7:0] fall;     // reported falling edges
  logic       pm_now;   // current match condition
  int         i;        // channel loop index

  // one combinational pass builds the whole next state
  // every field but rdat starts from its old value, so a branch that is not
  // taken simply holds; this keeps the block free of latches
  // the bus decode, the time base, the filters, the detectors and
  // the counters all read st and write next_st only; the pending clears also read next_st
  // decode and next-state logic
  always_comb begin
    next_st = st;
    tick    = (st.div == 12'(SAMPLE_CYC - 1));
    ftick   = tick && (st.fdiv == 6'(FILTER_TICKS - 1));
    // channel blocks run past the low byte, so decode the full address
    in_ch   = (wb_req.adr >= 32'(A_CH_BASE)) && (wb_req.adr <= 32'(A_TOP));
    ch      = 8'((wb_req.adr - 32'(A_CH_BASE)) >> 5);
    creg    = wb_req.adr[4:0];
    wr      = wb_req.cyc && wb_req.stb && wb_req.we && !st.ack;
    wrb     = wb_req.sel[0] ? wb_req.dat[7:0] : 8'h00;
    wrh     = {wb_req.sel[1] ? wb_req.dat[15:8] : 8'h00, wrb};
    // the contacts change at any time relative to clk_sys
    // only sync2 is read by logic; sync1 may be metastable
    // two flops before any logic reads the pins
    next_st.sync1 = isolated_input_n;
    next_st.sync2 = st.sync1;
    // the divider wraps after SAMPLE_CYC cycles and gives a one-cycle tick
    // the filter tick is a sub-multiple of the sample tick, so the two
    // always fall in the same cycle when the filter tick fires
    // both count from reset, so the first tick comes one full period later
    // time base: 100 us tick and 5 ms tick derived from it
    next_st.div = tick ? 12'h000 : st.div + 12'h001;
    if (tick) begin
      next_st.fdiv = (st.fdiv == 6'(FILTER_TICKS - 1)) ? 6'h00 : st.fdiv + 6'h01;
    end
    // unfiltered channels copy the synchronised level at each sample tick
    // filtered channels count filter ticks that disagree with the state
    // a single agreeing sample restarts the count, so chatter never
    // accumulates towards a change
    // the required count depends on the level being entered
    // a sampling number below the legal minimum is treated as the minimum
    // switching a filter off drops any partial count
    // per-channel input conditioning
    for (i = 0; i < NCH; i++) begin
      if (!st.filt_en[i]) begin
        if (tick) begin
          next_st.state[i] = st.sync2[i];  // follows at next sample
        end
        next_st.fcnt[i] = 16'h0000;
      end else if (ftick) begin  // filtered channel sampled each 5 ms
        if (st.sync2[i] == st.state[i]) begin
          next_st.fcnt[i] = 16'h0000;
        end else if (st.fcnt[i] + 16'h0001 >=
                     clamp_n(st.sync2[i] ? st.hi_n[i] : st.lo_n[i])) begin
          next_st.state[i] = st.sync2[i];
          next_st.fcnt[i]  = 16'h0000;
        end else begin
          next_st.fcnt[i] = st.fcnt[i] + 16'h0001;
        end
      end
    end
    // detectors and counters look at the reported state, never the pins,
    // so a filtered channel only raises events once its level is accepted
    // the edge copy lags the state by one cycle; edges last one cycle
    // edges of reported state feed the detectors
    rise   = st.state & ~st.state_q;
    fall   = ~st.state & st.state_q;
    pm_now = ((st.state ^ st.pm_val) & st.pm_en) == 8'h00;  // masked compare
    next_st.state_q = st.state;
    next_st.pm_q    = pm_now;
    // with no channel enabled the compare is trivially true; that case
    // raises nothing, but pm_q still tracks it, so enabling a channel
    // whose level already matches does not raise a false entry either
    // pattern match on entry only
    if (st.src_en[0] && st.pm_en != 8'h00 && pm_now && !st.pm_q) begin
      next_st.pend[0] = 1'b1;
    end
    // cos_mode bit 0 lets rising edges through, bit 1 falling ones
    // both bits set after reset, so any change counts by default
    // change of state on enabled channels
    if (st.src_en[1] && (((rise & {8{st.cos_mode[0]}}) |
                          (fall & {8{st.cos_mode[1]}})) & st.cos_en) != 8'h00) begin
      next_st.pend[1] = 1'b1;
    end
    // one event per selected edge of the reported state
    // the fastest unfiltered rate is one edge per sample tick, well above
    // the required event rate, so no event can be lost
    // reaching the top value marks overflow; the next event reloads
    // the match flag is raised as the counter becomes the match value
    // a disabled counter holds its value until it is enabled again
    // event counters
    for (i = 0; i < NCH; i++) begin
      if (st.cnt_en[i] && (st.cnt_edge[i] ? fall[i] : rise[i])) begin
        if (st.cnt[i] == 16'hffff) begin
          next_st.cnt[i] = st.rld[i];  // reload and go on
        end else begin
          next_st.cnt[i] = st.cnt[i] + 16'h0001;
          if (st.cnt[i] + 16'h0001 == 16'hffff && st.src_en[3]) begin
            next_st.opend[i] = 1'b1;  // reaching 65535 is overflow
          end
        end
        if (st.cnt[i] + 16'h0001 == st.mat[i] && st.cnt[i] != 16'hffff
            && st.src_en[2]) begin
          next_st.mpend[i] = 1'b1;  // match, counting continues
        end
      end
    end
    // a request is taken when cyc and stb are high and no ack stands
    // ack follows one cycle later and lasts one cycle, even if the master
    // still holds stb; read data is registered alongside it
    // unmapped reads answer with zero so software never sees stale data
    // bus answer: one ack per request, dropped the cycle after
    next_st.ack  = wb_req.cyc && wb_req.stb && !st.ack;
    next_st.rdat = 32'h00000000;
    if (wb_req.cyc && wb_req.stb && !st.ack && !wb_req.we) begin
      if (in_ch) begin
        if (creg == C_HI) begin
          next_st.rdat = {16'h0000, st.hi_n[ch[2:0]]};
        end else if (creg == C_LO) begin
          next_st.rdat = {16'h0000, st.lo_n[ch[2:0]]};
        end else if (creg == C_RLD) begin
          next_st.rdat = {16'h0000, st.rld[ch[2:0]]};
        end else if (creg == C_MAT) begin
          next_st.rdat = {16'h0000, st.mat[ch[2:0]]};
        end else if (creg == C_CNT) begin
          next_st.rdat = {16'h0000, st.cnt[ch[2:0]]};
        end
      end else if (wb_req.adr == {24'h0, A_STATE}) begin
        next_st.rdat = {24'h0, st.state};  // unfiltered bits refreshed each sample, filtered bits at 5 ms ticks
      end else if (wb_req.adr == {24'h0, A_FILT_EN}) begin
        next_st.rdat = {24'h0, st.filt_en};
      end else if (wb_req.adr == {24'h0, A_PM_EN}) begin
        next_st.rdat = {24'h0, st.pm_en};
      end else if (wb_req.adr == {24'h0, A_PM_VAL}) begin
        next_st.rdat = {24'h0, st.pm_val};
      end else if (wb_req.adr == {24'h0, A_COS_EN}) begin
        next_st.rdat = {24'h0, st.cos_en};
      end else if (wb_req.adr == {24'h0, A_COS_MODE}) begin
        next_st.rdat = {30'h0, st.cos_mode};
      end else if (wb_req.adr == {24'h0, A_CNT_EN}) begin
        next_st.rdat = {24'h0, st.cnt_en};
      end else if (wb_req.adr == {24'h0, A_CNT_EDGE}) begin
        next_st.rdat = {24'h0, st.cnt_edge};
      end else if (wb_req.adr == {24'h0, A_IRQ_EN}) begin
        next_st.rdat = {23'h0, st.irq_en, 4'h0, st.src_en};
      end else if (wb_req.adr == {24'h0, A_PEND}) begin
        next_st.rdat = {28'h0, |st.opend, |st.mpend, st.pend};
      end else if (wb_req.adr == {24'h0, A_MPEND}) begin
        next_st.rdat = {24'h0, st.mpend};
      end else if (wb_req.adr == {24'h0, A_OPEND}) begin
        next_st.rdat = {24'h0, st.opend};
      end
    end
    // writes land at the taking edge; byte lanes gate the data
    // an unselected lane writes zero into the 16-bit channel fields
    // the state byte and counter values are read only
    // pending flags clear by writing ones; a flag set in the same cycle
    // survives the clear so no event is lost
    // register writes; unmapped addresses ignored and read zero
    if (wr) begin
      if (in_ch) begin
        if (creg == C_HI) begin
          next_st.hi_n[ch[2:0]] = wrh;
        end else if (creg == C_LO) begin
          next_st.lo_n[ch[2:0]] = wrh;
        end else if (creg == C_RLD) begin
          next_st.rld[ch[2:0]] = wrh;
        end else if (creg == C_MAT) begin
          next_st.mat[ch[2:0]] = wrh;
        end
      end else if (wb_req.adr == {24'h0, A_FILT_EN}) begin
        next_st.filt_en = wrb;
      end else if (wb_req.adr == {24'h0, A_PM_EN}) begin
        next_st.pm_en = wrb;
      end else if (wb_req.adr == {24'h0, A_PM_VAL}) begin
        next_st.pm_val = wrb;
      end else if (wb_req.adr == {24'h0, A_COS_EN}) begin
        next_st.cos_en = wrb;
      end else if (wb_req.adr == {24'h0, A_COS_MODE}) begin
        next_st.cos_mode = wrb[1:0];
      end else if (wb_req.adr == {24'h0, A_CNT_EN}) begin
        // enabling a counter loads its reload value
        for (i = 0; i < NCH; i++) begin
          if (wrb[i] && !st.cnt_en[i]) begin
            next_st.cnt[i] = st.rld[i];
          end
        end
        next_st.cnt_en = wrb;
      end else if (wb_req.adr == {24'h0, A_CNT_EDGE}) begin
        next_st.cnt_edge = wrb;
      end else if (wb_req.adr == {24'h0, A_IRQ_EN}) begin
        next_st.src_en = wrb[3:0];
        if (wb_req.sel[1]) begin
          next_st.irq_en = wb_req.dat[8];  // one shared enable
        end
      end else if (wb_req.adr == {24'h0, A_PEND}) begin
        // clear unless set in the same cycle
        next_st.pend = next_st.pend & ~(wrb[1:0] & ~{
          (st.src_en[1] && next_st.pend[1] && !st.pend[1]),
          (next_st.pend[0] && !st.pend[0])});
      end else if (wb_req.adr == {24'h0, A_MPEND}) begin
        next_st.mpend = next_st.mpend & ~(wrb & ~(next_st.mpend & ~st.mpend));
      end else if (wb_req.adr == {24'h0, A_OPEND}) begin
        next_st.opend = next_st.opend & ~(wrb & ~(next_st.opend & ~st.opend));
      end
    end
    // the pin follows the next flags, so a clear drops it at once
    // irq_en gates only the pin; flags still collect while it is low
    // four sources, one gate
    next_st.irq = st.irq_en && ((|next_st.pend) || (|next_st.mpend) || (|next_st.opend));
  end

  // reset loads constants only: all enables off, counters at zero,
  // sampling numbers at their minimum and both edges selected
  // state register with asynchronous reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      for (int k = 0; k < NCH; k++) begin
        st.hi_n[k] <= FILT_RST;
        st.lo_n[k] <= FILT_RST;
      end
      st.cos_mode <= 2'h3;
    end else begin
      st <= next_st;
    end
  end

  // no logic between the state flops and the pins
  // outputs straight from flops
  assign wb_rsp.ack = st.ack;
  assign wb_rsp.dat = st.rdat;
  assign irq        = st.irq;

endmodule // iie_unit
